// *** rtl/gtb_pkg.sv ***
package gtb_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h0C;
    localparam logic [7:0] OFF_FLAG        = 8'h10;
    localparam logic [7:0] OFF_EVENT_GEN   = 8'h14;
    localparam logic [7:0] OFF_COUNT       = 8'h24;
    localparam logic [7:0] OFF_DIVIDER     = 8'h28;
    localparam logic [7:0] OFF_RELOAD      = 8'h2C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CR_CEN_BIT  = 0;
    localparam int CR_UPDATE_DISABLE_BIT = 1;
    localparam int CR_URS_BIT  = 2;
    localparam int CR_DIR_BIT  = 4;
    localparam int CR_CMS_BIT  = 5;
    localparam int CR_RELOAD_PRELOAD_EN_BIT = 7;
    localparam int IE_UIE_BIT  = 0;
    localparam int SR_UIF_BIT  = 0;
    localparam int EG_UG_BIT   = 0;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [15:0] RST_COUNT   = 16'h0000;
    localparam logic [15:0] RST_DIVIDER = 16'h0000;
    localparam logic [15:0] RST_RELOAD  = 16'hFFFF;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// *** rtl/gtb_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none

module gtb_prescaler #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] divider_value,
    input  wire logic         load,
    input  wire logic         restart,
    input  wire logic         run,
    output logic              tick
);

    // ------------------------------------------------------------
    // Buffered divider and divider counter
    // ------------------------------------------------------------
    logic [W-1:0] shadow;
    logic [W-1:0] pcount;

    initial begin
        if (W < 1) $error("gtb_prescaler: W must be at least 1");
    end

    // A new divider only takes hold on an update event, so a ratio
    // change never produces a short period mid-count.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shadow <= '0;
        end else if (load) begin
            shadow <= divider_value;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pcount <= '0;
        end else if (restart) begin
            pcount <= '0;
        end else if (run) begin
            pcount <= tick ? '0 : pcount + 1'b1;
        end
    end

    assign tick = run && (pcount == shadow);

endmodule
`default_nettype wire

// *** rtl/gtb_timer.sv ***
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module gtb_timer
    import gtb_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W  = 16
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   irq
);
    import gtb_pkg::*;

    initial begin
        if (ADDR_W < 6 || ADDR_W > 8) $error("gtb_timer: ADDR_W 6..8");
        if (CNT_W != 16) $error("gtb_timer: CNT_W must be 16");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              counter_enable_bit;
    logic              update_disable;
    logic              update_request_select;
    logic              dir;
    logic              center;
    logic              reload_preload_en;
    logic              irq_enable;
    logic              update_irq_flag;
    logic              cnt_en;
    logic [CNT_W-1:0]  count_value_reg;
    logic [CNT_W-1:0]  divider_value_reg;
    logic [CNT_W-1:0]  reload_value_reg;
    logic [CNT_W-1:0]  reload_shadow;
    logic [CNT_W-1:0]  reload_src;
    logic [CNT_W-1:0]  next_cnt;
    logic              next_dir;
    logic              wrap;
    logic              tick;
    logic              wr_fire;
    logic [31:0]       wr_word;
    logic              wr_ok;
    logic              update_generate;
    logic              update_event;
    logic              flag_set;
    logic [31:0]       rd_word;
    logic              rd_ok;

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    // Address and data are latched on their own handshakes; the
    // ready flags double as the "slot empty" markers.
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_word = {{8{w_strb[3]}}, {8{w_strb[2]}},
                      {8{w_strb[1]}}, {8{w_strb[0]}}} & w_data;

    function automatic logic [CNT_W-1:0] merge16(
        input logic [CNT_W-1:0] old_v,
        input logic [31:0]      data,
        input logic [3:0]       strb
    );
        merge16 = old_v;
        if (strb[0]) merge16[7:0] = data[7:0];
        if (strb[1]) merge16[15:8] = data[15:8];
    endfunction

    function automatic logic sel(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] off);
        sel = (a == off[ADDR_W-1:0]);
    endfunction

    always_comb begin
        wr_ok = sel(aw_addr, OFF_CONTROL_ONE) || sel(aw_addr, OFF_IRQ_ENABLE)
             || sel(aw_addr, OFF_FLAG) || sel(aw_addr, OFF_EVENT_GEN)
             || sel(aw_addr, OFF_COUNT) || sel(aw_addr, OFF_DIVIDER)
             || sel(aw_addr, OFF_RELOAD);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            aw_addr       <= '0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
        end else if (wr_fire) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_wready <= 1'b1;
            w_data       <= '0;
            w_strb       <= '0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end else if (wr_fire) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        if (sel(s_axi_araddr, OFF_CONTROL_ONE)) begin
            rd_word[CR_CEN_BIT]  = counter_enable_bit;
            rd_word[CR_UPDATE_DISABLE_BIT] = update_disable;
            rd_word[CR_URS_BIT]  = update_request_select;
            rd_word[CR_DIR_BIT]  = dir;
            rd_word[CR_CMS_BIT]  = center;
            rd_word[CR_RELOAD_PRELOAD_EN_BIT] = reload_preload_en;
        end else if (sel(s_axi_araddr, OFF_IRQ_ENABLE)) begin
            rd_word[IE_UIE_BIT] = irq_enable;
        end else if (sel(s_axi_araddr, OFF_FLAG)) begin
            rd_word[SR_UIF_BIT] = update_irq_flag;
        end else if (sel(s_axi_araddr, OFF_EVENT_GEN)) begin
            rd_word = '0;
        end else if (sel(s_axi_araddr, OFF_COUNT)) begin
            rd_word[CNT_W-1:0] = count_value_reg;
        end else if (sel(s_axi_araddr, OFF_DIVIDER)) begin
            rd_word[CNT_W-1:0] = divider_value_reg;
        end else if (sel(s_axi_araddr, OFF_RELOAD)) begin
            rd_word[CNT_W-1:0] = reload_value_reg;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            counter_enable_bit    <= 1'b0;
            update_disable        <= 1'b0;
            update_request_select <= 1'b0;
            center                <= 1'b0;
            reload_preload_en     <= 1'b0;
            irq_enable            <= 1'b0;
        end else if (wr_fire && sel(aw_addr, OFF_CONTROL_ONE)) begin
            if (w_strb[0]) begin
                counter_enable_bit    <= w_data[CR_CEN_BIT];
                update_disable        <= w_data[CR_UPDATE_DISABLE_BIT];
                update_request_select <= w_data[CR_URS_BIT];
                center                <= w_data[CR_CMS_BIT];
                reload_preload_en     <= w_data[CR_RELOAD_PRELOAD_EN_BIT];
            end
        end else if (wr_fire && sel(aw_addr, OFF_IRQ_ENABLE)) begin
            if (w_strb[0]) irq_enable <= w_data[IE_UIE_BIT];
        end
    end

    // The enable reaches the counter one clock after the control bit.
    always_ff @(posedge clk) begin
        if (!resetn) cnt_en <= 1'b0;
        else         cnt_en <= counter_enable_bit;
    end

    assign update_generate = wr_fire && sel(aw_addr, OFF_EVENT_GEN)
                           && wr_word[EG_UG_BIT];

    // ------------------------------------------------------------
    // Reload preload and shadow
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reload_value_reg  <= RST_RELOAD;
            divider_value_reg <= RST_DIVIDER;
        end else if (wr_fire && sel(aw_addr, OFF_RELOAD)) begin
            reload_value_reg <= merge16(reload_value_reg, w_data,
                                        w_strb);
        end else if (wr_fire && sel(aw_addr, OFF_DIVIDER)) begin
            divider_value_reg <= merge16(divider_value_reg, w_data,
                                         w_strb);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reload_shadow <= RST_RELOAD;
        end else if (!reload_preload_en || update_event) begin
            reload_shadow <= reload_value_reg;
        end
    end

    // A reload sees the new limit only while update_disable is clear; with it set, reload_shadow is used.
    assign reload_src = update_disable ? reload_shadow : reload_value_reg;

    // ------------------------------------------------------------
    // Counter and direction
    // ------------------------------------------------------------
    always_comb begin
        next_cnt = count_value_reg;
        next_dir = dir;
        wrap     = 1'b0;
        if (update_generate) begin
            next_cnt = (!center && dir) ? reload_src : '0;
            if (center) next_dir = 1'b0;
        end else if (tick) begin
            if (center) begin
                if (!dir) begin
                    if ({1'b0, count_value_reg} + 17'h00001
                        >= {1'b0, reload_shadow}) begin
                        next_cnt = reload_shadow;
                        next_dir = 1'b1;
                        wrap     = 1'b1;
                    end else begin
                        next_cnt = count_value_reg + 16'h0001;
                    end
                end else if (count_value_reg <= 16'h0001) begin
                    next_cnt = '0;
                    next_dir = 1'b0;
                    wrap     = 1'b1;
                end else begin
                    next_cnt = count_value_reg - 16'h0001;
                end
            end else if (!dir) begin
                if (count_value_reg >= reload_shadow) begin
                    next_cnt = '0;
                    wrap     = 1'b1;
                end else begin
                    next_cnt = count_value_reg + 16'h0001;
                end
            end else begin
                if (count_value_reg == '0) begin
                    next_cnt = reload_src;
                    wrap     = 1'b1;
                end else begin
                    next_cnt = count_value_reg - 16'h0001;
                end
            end
        end
    end

    // Software writes win over a tick in the same cycle.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_value_reg <= RST_COUNT;
        end else if (wr_fire && sel(aw_addr, OFF_COUNT)) begin
            count_value_reg <= merge16(count_value_reg, w_data,
                                       w_strb);
        end else begin
            count_value_reg <= next_cnt;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dir <= 1'b0;
        end else if (center) begin
            dir <= next_dir;
        end else if (wr_fire && sel(aw_addr, OFF_CONTROL_ONE)
                     && w_strb[0]) begin
            dir <= w_data[CR_DIR_BIT];
        end
    end

    // ------------------------------------------------------------
    // Update event, flag and interrupt
    // ------------------------------------------------------------
    assign update_event = update_generate
                        || (wrap && !update_disable);
    assign flag_set = (wrap && !update_disable)
                    || (update_generate && !update_request_select);

    // A set in the cycle of a clear wins, so no event is lost.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            update_irq_flag <= 1'b0;
        end else if (flag_set) begin
            update_irq_flag <= 1'b1;
        end else if (wr_fire && sel(aw_addr, OFF_FLAG) && w_strb[0]
                     && !w_data[SR_UIF_BIT]) begin
            update_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) irq <= 1'b0;
        else         irq <= update_irq_flag && irq_enable;
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    gtb_prescaler #(
        .W(CNT_W)
    ) u_prescaler (
        .clk           (clk),
        .resetn        (resetn),
        .divider_value (divider_value_reg),
        .load          (update_event),
        .restart       (update_generate),
        .run           (cnt_en),
        .tick          (tick)
    );

endmodule
`default_nettype wire

// *** rtl/gtb_timer_note_unused.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** testbench/gtb_timer_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module gtb_timer_checker
    import gtb_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              irq
);
    // ------------------------------------------------------------
    // Bus handshake checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    a_write_taken: assert property (s_axi_awvalid && s_axi_awready
        |=> !s_axi_awready) else $error("address slot not closed");
    a_slots_reopen: assert property ($rose(s_axi_bvalid)
        |-> s_axi_awready && s_axi_wready) else $error("slots closed");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write answer stuck");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("read not done");
    // Unmapped reads must not leak stale data from a neighbour.
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ADDR_W'(8'h04)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answer wrong");
    a_evgen_zero: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ADDR_W'(OFF_EVENT_GEN)
        |=> s_axi_rresp == RESP_OKAY && s_axi_rdata == 32'h0)
        else $error("event register read not zero");

    c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind gtb_timer gtb_timer_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

`default_nettype wire

// *** testbench/general_timer_time_base_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module general_timer_time_base_test;
    import gtb_pkg::*;
    typedef struct packed {logic w; logic [31:0] d; logic [1:0] r;} gtb_exp_s;
    localparam logic [31:0] EN   = 32'h1 << CR_CEN_BIT;
    localparam logic [31:0] UPDATE_DISABLE = 32'h1 << CR_UPDATE_DISABLE_BIT;
    localparam logic [31:0] UPDATE_REQUEST_SELECT  = 32'h1 << CR_URS_BIT;
    localparam logic [31:0] DIR  = 32'h1 << CR_DIR_BIT;
    localparam logic [31:0] CMS  = 32'h1 << CR_CMS_BIT;
    localparam logic [31:0] RELOAD_PRELOAD_EN = 32'h1 << CR_RELOAD_PRELOAD_EN_BIT;
    logic        clk, resetn, awvalid, awready, wvalid, wready, bvalid;
    logic        bready, arvalid, arready, rvalid, rready, irq, irq_q;
    logic        have_prev;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    gtb_exp_s    e;
    gtb_exp_s    exp_q[$];
    int          per_q[$];
    int          n_fail, samples_checked, cyc, prev, i;

    gtb_timer #(.ADDR_W(8), .CNT_W(16)) u_dut (
        .clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            $display("ERROR %s expected %h seen %h", nm, ex, got);
            n_fail++;
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tmo;
        $display("ERROR wait expected answer seen none");
        n_fail++;
        conclude();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY,
                      input logic [3:0] s = 4'hF);
        int k;
        exp_q.push_back({1'b1, d, r});
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clk);
            if (bvalid && bready) break;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            bready <= !awvalid && !wvalid;
        end
        bready <= 1'b0;
        if (k == 100) tmo();
    endtask

    // Read ready comes one cycle late on purpose, so the slave must hold.
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        int k;
        exp_q.push_back({1'b0, d, r});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clk);
            if (rvalid && rready) break;
            rready <= !arvalid;
            if (arready) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (k == 100) tmo();
    endtask

    task automatic wait_irq(input logic lvl);
        int k;
        for (k = 0; k < 400; k++) begin
            @(posedge clk);
            if (irq === lvl) break;
        end
        if (k == 400) tmo();
    endtask

    task automatic serve;
        wait_irq(1'b1);
        wr(OFF_FLAG, 32'h0);
        wait_irq(1'b0);
    endtask

    task automatic chk_irq(input logic ex);
        repeat (2) @(posedge clk);
        cmp("irq", {31'h0, ex}, {31'h0, irq});
    endtask

    // ------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if ((bvalid && bready) || (rvalid && rready)) begin
            if (exp_q.size() == 0) begin
                cmp("queue", 32'h0, 32'h1);
            end else begin
                e = exp_q.pop_front();
                if (e.w) begin
                    cmp("bresp", {30'h0, e.r}, {30'h0, bresp});
                end else begin
                    cmp("rresp", {30'h0, e.r}, {30'h0, rresp});
                    cmp("rdata", e.d, rdata);
                end
            end
        end
        if (irq === 1'b1 && irq_q !== 1'b1) begin
            if (have_prev && per_q.size() > 0) begin
                cmp("period", per_q.pop_front(), cyc - prev);
            end
            prev = cyc;
            have_prev = 1'b1;
        end
        irq_q = irq;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        {n_fail, samples_checked, cyc, prev} = {4{32'h0}};
        have_prev = 1'b0;
        irq_q = 1'b0;
        v = $urandom(32'hfee6416f);
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd(OFF_CONTROL_ONE, 32'h0);
        rd(OFF_IRQ_ENABLE, 32'h0);
        rd(OFF_FLAG, 32'h0);
        rd(OFF_COUNT, {16'h0, RST_COUNT});
        rd(OFF_DIVIDER, {16'h0, RST_DIVIDER});
        rd(OFF_RELOAD, {16'h0, RST_RELOAD});
        rd(OFF_EVENT_GEN, 32'h0);
        wr(8'h04, 32'hFFFF, RESP_SLVERR);
        rd(8'h04, 32'h0, RESP_SLVERR);
        $display("test reset done");
        for (i = 0; i < 3; i++) begin
            v = $urandom();
            wr(OFF_COUNT, {16'h0, v[15:0]});
            wr(OFF_DIVIDER, {16'h0, v[31:16]});
            wr(OFF_RELOAD, {16'h0, v[31:16] ^ v[15:0]});
            repeat (20) @(posedge clk);
            rd(OFF_COUNT, {16'h0, v[15:0]});
            rd(OFF_DIVIDER, {16'h0, v[31:16]});
            rd(OFF_RELOAD, {16'h0, v[31:16] ^ v[15:0]});
        end
        wr(OFF_COUNT, 32'h0000FFFF, RESP_OKAY, 4'h2);
        rd(OFF_COUNT, {16'h0, 8'hFF, v[7:0]});
        $display("test access done");
        wr(OFF_IRQ_ENABLE, 32'h1);
        wr(OFF_CONTROL_ONE, UPDATE_REQUEST_SELECT);
        wr(OFF_EVENT_GEN, 32'h1);
        rd(OFF_FLAG, 32'h0);
        chk_irq(1'b0);
        wr(OFF_CONTROL_ONE, 32'h0);
        wr(OFF_COUNT, 32'h5);
        wr(OFF_EVENT_GEN, 32'h1);
        rd(OFF_FLAG, 32'h1);
        rd(OFF_COUNT, 32'h0);
        chk_irq(1'b1);
        wr(OFF_IRQ_ENABLE, 32'h0);
        chk_irq(1'b0);
        wr(OFF_FLAG, 32'h0);
        rd(OFF_FLAG, 32'h0);
        wr(OFF_CONTROL_ONE, DIR);
        wr(OFF_RELOAD, 32'h33);
        wr(OFF_EVENT_GEN, 32'h1);
        rd(OFF_COUNT, 32'h33);
        $display("test update done");
        // Periods are (reload + 1) * (divider + 1) kernel cycles, reload * (divider + 1) in centre mode.
        wr(OFF_IRQ_ENABLE, 32'h1);
        wr(OFF_DIVIDER, 32'h1);
        wr(OFF_RELOAD, 32'h9);
        wr(OFF_CONTROL_ONE, RELOAD_PRELOAD_EN);
        wr(OFF_EVENT_GEN, 32'h1);
        wr(OFF_FLAG, 32'h0);
        have_prev = 1'b0;
        wr(OFF_CONTROL_ONE, RELOAD_PRELOAD_EN | EN);
        serve();
        per_q.push_back(20);
        serve();
        wr(OFF_DIVIDER, 32'h2);
        wr(OFF_RELOAD, 32'h5);
        per_q.push_back(20);
        per_q.push_back(18);
        per_q.push_back(18);
        repeat (3) serve();
        wr(OFF_CONTROL_ONE, RELOAD_PRELOAD_EN | EN | DIR);
        have_prev = 1'b0;
        serve();
        per_q.push_back(18);
        serve();
        wr(OFF_CONTROL_ONE, RELOAD_PRELOAD_EN | EN | CMS);
        have_prev = 1'b0;
        serve();
        per_q.push_back(15);
        serve();
        $display("test period done");
        wr(OFF_CONTROL_ONE, RELOAD_PRELOAD_EN | EN | UPDATE_DISABLE);
        wr(OFF_FLAG, 32'h0);
        repeat (60) @(posedge clk);
        rd(OFF_FLAG, 32'h0);
        chk_irq(1'b0);
        wr(OFF_CONTROL_ONE, 32'h0);
        $display("test disable done");
        conclude();
    end
endmodule

`default_nettype wire
